// ### include/fcd_link_if.sv
// Purpose: 16-bit parallel register bus between host and device
// Assumes: single clock, strobes are one-cycle pulses
// Notes:   joined by the testbench
`timescale 1ns/100ps
`default_nettype none
interface fcd_link_if;
  logic        wr_stb;
  logic [15:0] wr_data;
  logic        rd_stb;
  logic [15:0] rd_data;
  logic        rd_valid;

  modport dev (input wr_stb, input wr_data, input rd_stb,
               output rd_data, output rd_valid);
  modport host (output wr_stb, output wr_data, output rd_stb,
                input rd_data, input rd_valid);
endinterface
`default_nettype wire

// ### include/fcd_pkg.sv
// Purpose: shared constants for the coefficient download link
// Assumes: both ends run on pclk, 16-bit write words
// Notes:   host apb offsets live here too
package fcd_pkg;
  // ----------------------------------------------------------------
  // word and coefficient layout
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned COEFF_W    = 27;
  localparam int unsigned MAG_HI_W   = 11;  // sign plus magnitude 25:16
  localparam int unsigned PAD_W      = 5;
  localparam int unsigned IDX_W      = 6;
  localparam logic [5:0]  MAX_COEFF  = 6'h30;
  localparam logic [5:0]  COEFF_STEP = 6'h06;

  // ----------------------------------------------------------------
  // first control register of the device
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL1_ADDR      = 16'h0001;
  localparam logic [15:0] CTRL1_RESET     = 16'h001A;
  localparam int unsigned CTRL_LOAD_BIT   = 15;
  localparam int unsigned CTRL_RD_STAT    = 11;
  localparam int unsigned CTRL_SEL_LSB    = 5;
  localparam int unsigned CTRL_SEL_W      = 4;
  localparam int unsigned CTRL_BYP_BIT    = 4;
  localparam int unsigned CTRL_DEC_W      = 3;

  // ----------------------------------------------------------------
  // status word and plain data word
  // ----------------------------------------------------------------
  localparam int unsigned ST_OK_BIT    = 7;
  localparam int unsigned ST_FOK_BIT   = 6;
  localparam int unsigned ST_UFILT_BIT = 5;
  localparam int unsigned ST_BYP_BIT   = 4;
  localparam int unsigned ST_ONE_BIT   = 3;
  localparam int unsigned DATA_OK_BIT  = 0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 4;
  localparam int unsigned CORE_PERIOD_NS = 4;  // core clock equals pclk
  localparam logic [5:0]  FILL_PER_CYC   = 6'h02;

  // ----------------------------------------------------------------
  // host apb map
  // ----------------------------------------------------------------
  localparam logic [7:0] APB_CTRL   = 8'h00;
  localparam logic [7:0] APB_COEFF  = 8'h04;
  localparam logic [7:0] APB_READ   = 8'h08;
  localparam logic [7:0] APB_STATUS = 8'h0C;
  localparam int unsigned HS_BUSY_BIT = 16;
  localparam int unsigned HS_DL_BIT   = 17;
  localparam int unsigned HS_OK_BIT   = 18;
endpackage

// ### rtl/fcd_device.sv
// Purpose: device end, receives and checks user fir coefficients
// Assumes: one write word per cycle at most, core clock is pclk
// Notes:   coefficient store is flops so reset can clear it
`timescale 1ns/100ps
`default_nettype none
module fcd_device (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  fcd_link_if.dev          link,
  input  wire logic [5:0]  coeff_addr,
  output logic      [26:0] coeff_data,
  output logic             user_filter_active,
  output logic      [3:0]  tap_count_sel,
  output logic             coeff_load_ok,
  output logic             load_busy
);
  typedef enum logic [2:0] {
    S_ADDR, S_DATA, S_HI, S_LO, S_SUM, S_FILL
  } fcd_dst_t;

  fcd_dst_t    state_q;
  fcd_dst_t    state_d;
  logic        hit_q;
  logic [10:0] hi_q;
  logic [5:0]  idx_q;
  logic [5:0]  n_q;
  logic [5:0]  fill_q;
  logic [15:0] sum_q;
  logic        ok_q;
  logic        user_q;
  logic        busy_q;
  logic        rd_stat_q;
  logic [3:0]  sel_q;
  logic        byp_q;
  logic [2:0]  dec_q;
  logic [26:0] mem_q [0:47];
  logic [26:0] coeff_q;

  // ----------------------------------------------------------------
  // decode of incoming words
  // ----------------------------------------------------------------
  logic        wr;
  logic [15:0] wd;
  logic        arm;
  logic        ctrl_wr;
  logic [3:0]  sel_in;
  logic        last_lo;
  logic        fill_end;
  assign wr      = ce && link.wr_stb;
  assign wd      = link.wr_data;
  assign ctrl_wr = wr && state_q == S_DATA && hit_q;
  assign sel_in  = wd[fcd_pkg::CTRL_SEL_LSB +: fcd_pkg::CTRL_SEL_W];
  // request plus an odd nonzero tap code arms a load
  assign arm     = ctrl_wr && wd[fcd_pkg::CTRL_LOAD_BIT] && sel_in[0];
  assign last_lo = idx_q == n_q - 6'h01;
  assign fill_end = fill_q + fcd_pkg::FILL_PER_CYC >= fcd_pkg::MAX_COEFF;

  // next state of the write decoder
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_ADDR: begin
        if (wr) begin
          state_d = S_DATA;  // address word then data
        end
      end
      S_DATA: begin
        if (wr) begin
          state_d = arm ? S_HI : S_ADDR;
        end
      end
      S_HI: begin
        if (wr) begin
          state_d = S_LO;  // upper word comes first
        end
      end
      S_LO: begin
        if (wr) begin
          state_d = last_lo ? S_SUM : S_HI;
        end
      end
      S_SUM: begin
        if (wr) begin
          state_d = (n_q == fcd_pkg::MAX_COEFF) ? S_ADDR : S_FILL;
        end
      end
      S_FILL: begin
        if (fill_end) begin
          state_d = S_ADDR;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state and busy flag
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_ADDR;
      busy_q  <= 1'b0;
      hit_q   <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      // busy flag clears itself when the load ends
      busy_q  <= state_d != S_ADDR && state_d != S_DATA;
      if (wr && state_q == S_ADDR) begin
        hit_q <= wd == fcd_pkg::CTRL1_ADDR;
      end
    end
  end

  // ----------------------------------------------------------------
  // control fields kept from the first control register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q     <= fcd_pkg::CTRL1_RESET[8:5];
      byp_q     <= fcd_pkg::CTRL1_RESET[fcd_pkg::CTRL_BYP_BIT];
      dec_q     <= fcd_pkg::CTRL1_RESET[2:0];
      rd_stat_q <= 1'b0;
    end else if (ce) begin
      if (ctrl_wr) begin
        sel_q <= sel_in;
        byp_q <= wd[fcd_pkg::CTRL_BYP_BIT];
        dec_q <= wd[fcd_pkg::CTRL_DEC_W-1:0];
      end
      // one-shot: next read returns status
      if (ctrl_wr && wd[fcd_pkg::CTRL_RD_STAT]) begin
        rd_stat_q <= 1'b1;
      end else if (link.rd_stb) begin
        rd_stat_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // coefficient counting and running byte sum
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_q  <= 6'h00;
      n_q    <= 6'h00;
      hi_q   <= 11'h000;
      sum_q  <= 16'h0000;
      fill_q <= 6'h00;
    end else if (ce) begin
      if (arm) begin
        idx_q <= 6'h00;
        n_q   <= 6'(({3'b000, sel_in[3:1]} + 6'h01) *
                    fcd_pkg::COEFF_STEP);  // 6 per step
        sum_q <= 16'h0000;
      end
      // every word of a coefficient adds its two bytes
      if (wr && (state_q == S_HI || state_q == S_LO)) begin
        sum_q <= sum_q + 16'(wd[15:8]) + 16'(wd[7:0]);
      end
      if (wr && state_q == S_HI) begin
        hi_q <= wd[fcd_pkg::MAG_HI_W-1:0];  // pad bits dropped
      end
      if (wr && state_q == S_LO) begin
        idx_q <= idx_q + 6'h01;
      end
      if (wr && state_q == S_SUM) begin
        fill_q <= n_q;
      end else if (state_q == S_FILL) begin
        fill_q <= fill_q + fcd_pkg::FILL_PER_CYC;
      end
    end
  end

  // ----------------------------------------------------------------
  // result flags
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ok_q   <= 1'b0;
      user_q <= 1'b0;  // default coefficients after reset
    end else if (ce) begin
      if (arm) begin
        ok_q   <= 1'b0;
        user_q <= 1'b0;
      end else if (ctrl_wr && wd[fcd_pkg::CTRL_LOAD_BIT]) begin
        user_q <= 1'b0;  // even tap code keeps the default filter
      end else if (wr && state_q == S_SUM) begin
        ok_q   <= sum_q == wd;  // compare with the host sum
        user_q <= sum_q == wd;
      end
    end
  end

  // ----------------------------------------------------------------
  // coefficient store, cleared by reset
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 48; i++) begin
        mem_q[i] <= 27'h0000000;  // volatile, lost on reset
      end
    end else if (ce) begin
      if (wr && state_q == S_LO) begin
        // sign and magnitude stored as sent
        mem_q[idx_q] <= {hi_q, wd};
      end
      if (state_q == S_FILL) begin
        mem_q[fill_q] <= 27'h0000000;  // zero unused slots
        mem_q[fill_q + 6'h01] <= 27'h0000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // read answers and filter side outputs
  // ----------------------------------------------------------------
  logic [15:0] status_w;
  always_comb begin
    status_w = 16'h0000;
    status_w[fcd_pkg::ST_OK_BIT]    = ok_q;
    status_w[fcd_pkg::ST_FOK_BIT]   = ok_q;
    status_w[fcd_pkg::ST_UFILT_BIT] = user_q;
    status_w[fcd_pkg::ST_BYP_BIT]   = byp_q;
    status_w[fcd_pkg::ST_ONE_BIT]   = 1'b1;
    status_w[fcd_pkg::CTRL_DEC_W-1:0] = dec_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.rd_data  <= 16'h0000;
      link.rd_valid <= 1'b0;
      coeff_q       <= 27'h0000000;
    end else if (ce) begin
      link.rd_valid <= link.rd_stb;
      if (link.rd_stb) begin
        // status word, or data word carrying the ok flag
        link.rd_data <= rd_stat_q ? status_w :
                        {15'h0000, ok_q};
      end
      coeff_q <= (coeff_addr < fcd_pkg::MAX_COEFF) ?
                 mem_q[coeff_addr] : 27'h0000000;
    end
  end

  assign coeff_data         = coeff_q;
  assign user_filter_active = user_q;
  assign tap_count_sel      = sel_q;
  assign coeff_load_ok      = ok_q;
  assign load_busy          = busy_q;
endmodule
`default_nettype wire

// ### rtl/fcd_host.sv
// Purpose: host end, turns apb orders into link word sequences
// Assumes: one link word per cycle, device answers reads in 1 cycle
// Notes:   apb writes to mapped offsets stall while a sequence is running
`timescale 1ns/100ps
`default_nettype none
module fcd_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  fcd_link_if.host         link
);
  typedef enum logic [2:0] {H_IDLE, H_SEND, H_WAIT, H_RD, H_RDW} fcd_hst_t;

  fcd_hst_t    state_q;
  logic [15:0] q_q [0:2];
  logic [1:0]  n_q;
  logic        then_wait_q;
  logic        then_rd_q;
  logic [7:0]  wait_q;
  logic        dl_q;
  logic [5:0]  left_q;
  logic [5:0]  total_q;
  logic [15:0] sum_q;
  logic [15:0] shadow_q;
  logic [15:0] last_rd_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic        mapped;
  logic        take;
  logic        act;
  logic [15:0] hi_w;
  logic [15:0] sum_n;
  logic [31:0] status;
  assign mapped = (paddr == fcd_pkg::APB_CTRL) ||
                  (paddr == fcd_pkg::APB_COEFF) ||
                  (paddr == fcd_pkg::APB_READ) ||
                  (paddr == fcd_pkg::APB_STATUS);
  // writes that start a sequence wait for idle
  assign take = ce && psel && penable && !pready_q &&
                (!pwrite || !mapped || state_q == H_IDLE);
  assign act = take && pwrite && mapped;
  assign hi_w = {5'h00, pwdata[26:16]};  // pad with zeros
  // byte sum of the padded word
  assign sum_n = sum_q + 16'(hi_w[15:8]) + 16'(hi_w[7:0]) +
                 16'(pwdata[15:8]) + 16'(pwdata[7:0]);
  assign status = {13'h0000, last_rd_q[fcd_pkg::ST_OK_BIT], dl_q,
                   state_q != H_IDLE, last_rd_q};

  // answer one cycle after the transfer is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (ce) begin
      pready_q  <= take;
      pslverr_q <= take && (!mapped ||
                   (pwrite && paddr == fcd_pkg::APB_COEFF && !dl_q));
      prdata_q  <= (take && !pwrite && paddr == fcd_pkg::APB_STATUS) ?
                   status : 32'h0000_0000;
    end
  end
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;

  // wait of half a core period per unused slot, rounded up
  function automatic logic [7:0] fill_wait(input logic [5:0] used);
    int unsigned unused;
    unused = int'(fcd_pkg::MAX_COEFF) - int'(used);
    fill_wait = 8'((unused * fcd_pkg::CORE_PERIOD_NS +
                    2 * fcd_pkg::CLK_PERIOD_NS - 1) /
                   (2 * fcd_pkg::CLK_PERIOD_NS));
  endfunction

  // ----------------------------------------------------------------
  // download bookkeeping
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dl_q     <= 1'b0;
      left_q   <= 6'h00;
      total_q  <= 6'h00;
      sum_q    <= 16'h0000;
      shadow_q <= fcd_pkg::CTRL1_RESET;
    end else if (ce && act && paddr == fcd_pkg::APB_CTRL) begin
      shadow_q <= pwdata[15:0];
      // arm only with request and a valid tap count together
      dl_q     <= pwdata[fcd_pkg::CTRL_LOAD_BIT] &&
                  pwdata[fcd_pkg::CTRL_SEL_LSB];
      left_q   <= 6'(({3'b000, pwdata[8:6]} + 6'h01) *
                     fcd_pkg::COEFF_STEP);
      total_q  <= 6'(({3'b000, pwdata[8:6]} + 6'h01) *
                     fcd_pkg::COEFF_STEP);
      sum_q    <= 16'h0000;
    end else if (ce && act && paddr == fcd_pkg::APB_COEFF && dl_q) begin
      sum_q  <= sum_n;
      left_q <= left_q - 6'h01;
      dl_q   <= (left_q != 6'h01);
    end
  end

  // ----------------------------------------------------------------
  // link sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= H_IDLE;
      q_q[0]      <= 16'h0000;
      q_q[1]      <= 16'h0000;
      q_q[2]      <= 16'h0000;
      n_q         <= 2'h0;
      then_wait_q <= 1'b0;
      then_rd_q   <= 1'b0;
      wait_q      <= 8'h00;
      link.wr_stb  <= 1'b0;
      link.wr_data <= 16'h0000;
      link.rd_stb  <= 1'b0;
      last_rd_q   <= 16'h0000;
    end else if (ce) begin
      link.wr_stb <= 1'b0;
      link.rd_stb <= 1'b0;
      unique case (state_q)
        H_IDLE: begin
          then_wait_q <= 1'b0;
          then_rd_q   <= 1'b0;
          if (act && paddr == fcd_pkg::APB_CTRL) begin
            // address word then data word
            q_q[0]  <= fcd_pkg::CTRL1_ADDR;
            q_q[1]  <= pwdata[15:0];
            n_q     <= 2'h2;
            state_q <= H_SEND;
          end else if (act && paddr == fcd_pkg::APB_COEFF && dl_q) begin
            // upper word first, then lower
            q_q[0]  <= hi_w;
            q_q[1]  <= pwdata[15:0];
            q_q[2]  <= sum_n;  // checksum after the last one
            n_q     <= (left_q == 6'h01) ? 2'h3 : 2'h2;
            then_wait_q <= (left_q == 6'h01);
            wait_q  <= fill_wait(total_q);
            state_q <= H_SEND;
          end else if (act && paddr == fcd_pkg::APB_READ) begin
            // readback keeps tap count and decimation
            q_q[0]    <= fcd_pkg::CTRL1_ADDR;
            q_q[1]    <= {4'h0, 1'b1, 2'b00, shadow_q[8:0]};
            n_q       <= pwdata[0] ? 2'h2 : 2'h0;
            then_rd_q <= 1'b1;
            state_q   <= pwdata[0] ? H_SEND : H_RD;
          end
        end
        H_SEND: begin
          link.wr_stb  <= 1'b1;
          link.wr_data <= q_q[0];
          q_q[0] <= q_q[1];
          q_q[1] <= q_q[2];
          n_q    <= n_q - 2'h1;
          if (n_q == 2'h1) begin
            state_q <= then_wait_q ? H_WAIT :
                       (then_rd_q ? H_RD : H_IDLE);
          end
        end
        H_WAIT: begin
          // hold off while the device zero fills
          if (wait_q == 8'h00) begin
            state_q <= H_IDLE;
          end else begin
            wait_q <= wait_q - 8'h01;
          end
        end
        H_RD: begin
          link.rd_stb <= 1'b1;
          state_q     <= H_RDW;
        end
        H_RDW: begin
          if (link.rd_valid) begin
            last_rd_q <= link.rd_data;  // ok flag seen here
            state_q   <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### verif/fcd_link_chk.sv
// Purpose: protocol checker for the coefficient download link
// Assumes: one clock, host sends upper and lower word back to back
// Notes:   sees only the interface signals
`timescale 1ns/100ps
`default_nettype none
module fcd_link_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        wr_stb,
  input wire logic [15:0] wr_data,
  input wire logic        rd_stb,
  input wire logic [15:0] rd_data,
  input wire logic        rd_valid
);
  logic        exp_q;
  logic        stat_q;
  logic [6:0]  left_q;
  logic [5:0]  wait_q;
  logic [5:0]  quiet_q;
  logic [15:0] sum_q;
  // ----------
  // download tracker
  // ----------
  // words left, byte sum and quiet span after the checksum
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exp_q <= 1'b0;
      stat_q <= 1'b0;
      left_q <= 7'h00;
      wait_q <= 6'h00;
      quiet_q <= 6'h00;
      sum_q <= 16'h0000;
    end else begin
      if (wr_stb)
        exp_q <= left_q == 7'h00 && !exp_q &&
                 wr_data == fcd_pkg::CTRL1_ADDR;
      if (wr_stb && exp_q)
        stat_q <= stat_q | wr_data[11];
      else if (rd_stb)
        stat_q <= 1'b0;
      if (wr_stb && left_q != 7'h00)
        left_q <= left_q - 7'h01;
      else if (wr_stb && exp_q && wr_data[15] && wr_data[5]) begin
        left_q <= 7'(({3'h0, wr_data[8:5]} + 7'h01) * 7'h06 + 7'h01);
        wait_q <= 6'((6'h30 -
                      6'(({2'h0, wr_data[8:5]} + 6'h01) * 6'h03)) >> 1);
      end
      if (wr_stb && exp_q)
        sum_q <= 16'h0000;
      else if (wr_stb && left_q > 7'h01)
        sum_q <= sum_q + {8'h00, wr_data[15:8]} + {8'h00, wr_data[7:0]};
      if (wr_stb && left_q == 7'h01)
        quiet_q <= wait_q;
      else if (quiet_q != 6'h00)
        quiet_q <= quiet_q - 6'h01;
    end
  end
  // ----------
  // assertions
  // ----------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_arm_addr;
    wr_stb && left_q == 7'h00 && !exp_q && wr_data == fcd_pkg::CTRL1_ADDR;
  endsequence
  sequence s_hi;
    wr_stb && left_q > 7'h01 && left_q[0];
  endsequence
  sequence s_read;
    rd_stb ##1 rd_valid;
  endsequence
  AST_ADDR_DATA: assert property (s_arm_addr |=> wr_stb)
    else $error("address word not followed by data word");
  AST_PAD: assert property (s_hi |-> wr_data[15:11] == 5'h00)
    else $error("upper word padding not zero");
  AST_PAIR: assert property (s_hi |=> wr_stb && !left_q[0])
    else $error("lower word does not follow upper word");
  AST_CKSUM: assert property (
    wr_stb && left_q == 7'h01 |-> wr_data == sum_q)
    else $error("checksum word differs from byte sum");
  AST_FILL_GAP: assert property (wr_stb |-> quiet_q == 6'h00)
    else $error("write during zero fill");
  AST_RD_ANSWER: assert property (rd_stb |-> s_read)
    else $error("read not answered next cycle");
  AST_RD_CAUSE: assert property (rd_valid |-> $past(rd_stb))
    else $error("read answer without request");
  AST_RD_HOLD: assert property (!rd_valid |-> $stable(rd_data))
    else $error("read data changed without read");
  AST_STATUS: assert property (
    rd_stb && stat_q |=> rd_data[3] && rd_data[7] == rd_data[6])
    else $error("status word malformed");
  AST_PLAIN: assert property (
    rd_stb && !stat_q |=> rd_data[15:1] == 15'h0000)
    else $error("plain read word malformed");
endmodule
`default_nettype wire

// ### verif/test_fir_coefficient_download.sv
// Purpose: testbench for host and device joined by the link
// Assumes: apb on the host, device outputs watched directly
// Notes:   host computes checksums itself
`timescale 1ns/100ps
`default_nettype none
module test_fir_coefficient_download;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, e;
  logic        user_filter_active, coeff_load_ok, load_busy;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [5:0]  coeff_addr;
  logic [26:0] coeff_data;
  logic [3:0]  tap_count_sel;
  logic [15:0] last_wd;
  int          bad_count, compares;
  logic [31:0] ex [12] = '{32'h032B9688, 32'h01BF183C, 32'h00156626,
    32'h04A81E6A, 32'h045F2A96, 32'h002C49C2, 32'h0050E9F6, 32'h0010DBD8,
    32'h042FDE54, 32'h0437445A, 32'h041B7D6E, 32'h04043B5F};
  fcd_link_if link ();
  fcd_host fcd_host_i (.pclk(pclk), .presetn(presetn), .ce(ce),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link));
  fcd_device fcd_device_i (.pclk(pclk), .presetn(presetn), .ce(ce),
    .link(link), .coeff_addr(coeff_addr), .coeff_data(coeff_data),
    .user_filter_active(user_filter_active), .tap_count_sel(tap_count_sel),
    .coeff_load_ok(coeff_load_ok), .load_busy(load_busy));
  fcd_link_chk fcd_link_chk_i (.pclk(pclk), .presetn(presetn),
    .wr_stb(link.wr_stb), .wr_data(link.wr_data), .rd_stb(link.rd_stb),
    .rd_data(link.rd_data), .rd_valid(link.rd_valid));
  // ----------
  // clock, link monitor, watchdog
  // ----------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // last word written on the link
  always @(posedge pclk) if (link.wr_stb === 1'b1) last_wd <= link.wr_data;
  initial begin
    #200000;
    bad_count++;
    results();
  end
  // ----------
  // helpers
  // ----------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("mismatches=%0d compares=%0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one apb transfer, answer left in r and e
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 3000);
    if (n >= 3000) bad_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [26:0] cv(input int i);
    return {i[0], 26'(i * 40503 + 11)};
  endfunction
  // poll host status until host and device are idle
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, fcd_pkg::APB_STATUS, 32'h0);
      n++;
    end while ((r[fcd_pkg::HS_BUSY_BIT] !== 1'b0 || load_busy !== 1'b0)
               && n < 500);
    if (n >= 500) bad_count++;
  endtask
  task automatic slot(input int a, input logic [26:0] x);
    coeff_addr <= 6'(a);
    @(posedge pclk);
    @(posedge pclk);
    chk({5'h0, coeff_data}, {5'h0, x});
  endtask
  task automatic load(input logic [3:0] c, input int n, input bit x);
    apb(1'b1, fcd_pkg::APB_CTRL, 32'h8019 | (32'(c) << 5));
    for (int i = 0; i < n; i++) begin
      apb(1'b1, fcd_pkg::APB_COEFF,
          {5'h0, x ? ex[i][26:0] : cv(i)});
      chk({31'h0, e}, 32'h0);
    end
    wait_idle();
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic t_reset_state();
    chk({29'h0, user_filter_active, coeff_load_ok, load_busy}, 0);
    slot(0, 27'h0);
  endtask
  task automatic t_refuse();
    apb(1'b1, fcd_pkg::APB_COEFF, 32'h1);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask
  task automatic t_all_codes();
    for (int c = 15; c > 0; c -= 2) begin
      load(4'(c), (c + 1) * 3, 1'b0);
      chk({28'h0, tap_count_sel}, 32'(c));
      chk({30'h0, coeff_load_ok, user_filter_active}, 32'h3);
      slot(0, cv(0));
      slot((c + 1) * 3 - 1, cv((c + 1) * 3 - 1));
      if (c < 15) slot((c + 1) * 3, 27'h0);
    end
  endtask
  task automatic t_example();
    load(4'h3, 12, 1'b1);
    chk({16'h0, last_wd}, 32'h0E6B);
    slot(3, 27'h4A81E6A);
    slot(47, 27'h0);
    apb(1'b1, fcd_pkg::APB_READ, 32'h1);
    wait_idle();
    chk({24'h0, r[7:0]}, 32'hF9);
    apb(1'b1, fcd_pkg::APB_READ, 32'h0);
    wait_idle();
    chk({16'h0, r[15:0]}, 32'h1);
  endtask
  task automatic t_default();
    apb(1'b1, fcd_pkg::APB_CTRL, 32'h8019);
    wait_idle();
    chk({31'h0, user_filter_active}, 32'h0);
    // even tap code with request arms nothing
    apb(1'b1, fcd_pkg::APB_CTRL, 32'h8059);
    wait_idle();
    chk({28'h0, tap_count_sel}, 32'h2);
    chk({31'h0, load_busy}, 32'h0);
    apb(1'b1, fcd_pkg::APB_COEFF, 32'h1);
    chk({31'h0, e}, 32'h1);
  endtask
  task automatic t_mid_reset();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    slot(0, 27'h0);
    chk({28'h0, tap_count_sel}, 32'h0);
    chk({31'h0, coeff_load_ok}, 32'h0);
  endtask
  // ----------
  // main sequence
  // ----------
  initial begin
    ce = 1'b1;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    coeff_addr = 6'h00;
    bad_count = 0;
    compares = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_state();
    t_refuse();
    t_all_codes();
    t_example();
    t_default();
    t_mid_reset();
    results();
  end
endmodule
`default_nettype wire
